/* File: src/pli_ctrl.sv */
// pick-light indicator controller: registers, visual states, delays
`timescale 1ns/1ps
module pli_ctrl #(
  parameter int TICK_CYCLES = pli_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic act_i,
  input wire logic sec_act_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  output logic [4:0] vis_state_o,
  output logic [15:0] quad_color_o,
  output logic [7:0] level_o
);
  typedef enum logic [4:0] {
    PLI_WAIT = 5'b00001,
    PLI_JOB = 5'b00010,
    PLI_MISPICK = 5'b00100,
    PLI_ACK = 5'b01000,
    PLI_SACK = 5'b10000
  } pli_state_t;

  pli_anim_if anim_bus ();

  logic [15:0] mode, next_mode;
  logic [15:0] job, next_job;
  logic [15:0] b_anim, next_b_anim;
  logic [15:0] b_color, next_b_color;
  logic [15:0] cfg [pli_pkg::NUM_CFG];
  logic ovr_anim, next_ovr_anim;
  logic ovr_color, next_ovr_color;
  logic [15:0] rdata, next_rdata;
  logic ack, err;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick;
  pli_state_t state, next_state;
  logic pend, next_pend;
  logic pend_sec, next_pend_sec;
  logic [15:0] dly, next_dly;
  logic cfg_hit, cfg_ok, reg_hit;
  logic [6:0] cfg_dec;
  logic [5:0] cfg_idx;
  int blk;

  // config address to config register index; miss in the gaps between blocks
  function automatic logic [6:0] cfg_decode(input logic [15:0] addr);
    logic [15:0] d;
    int b;
    int o;
    d = addr - pli_pkg::ADDR_CFG_BASE;
    b = int'(d) / pli_pkg::BLK_STRIDE;
    o = int'(d) % pli_pkg::BLK_STRIDE;
    if (addr < pli_pkg::ADDR_CFG_BASE || b >= pli_pkg::NUM_BLK
        || o >= pli_pkg::BLK_REGS)
      cfg_decode = 7'h00;
    else
      cfg_decode = {1'b1, 6'(b * pli_pkg::BLK_REGS + o)};
  endfunction

  function automatic logic cfg_valid(input int fld, input logic [15:0] v);
    case (fld)
      pli_pkg::F_ANIM: cfg_valid = v <= 16'(pli_pkg::AN_SWEEP);
      pli_pkg::F_COLOR1, pli_pkg::F_COLOR2:
        cfg_valid = v <= pli_pkg::COLOR_MAX;
      pli_pkg::F_PATTERN: cfg_valid = v <= 16'(pli_pkg::PT_MAX);
      default: cfg_valid = 1'b1;
    endcase
  endfunction

  function automatic logic anim_valid(input logic [15:0] v);
    anim_valid = v <= pli_pkg::BASIC_ANIM_MAX
      || (v >= pli_pkg::BASIC_BURST_LO && v <= pli_pkg::BASIC_BURST_HI);
  endfunction

  function automatic int state_blk(input pli_state_t s);
    case (s)
      PLI_JOB: state_blk = pli_pkg::BLK_JOB;
      PLI_MISPICK: state_blk = pli_pkg::BLK_MISPICK;
      PLI_ACK: state_blk = pli_pkg::BLK_ACK;
      PLI_SACK: state_blk = pli_pkg::BLK_SACK;
      default: state_blk = pli_pkg::BLK_WAIT;
    endcase
  endfunction

  // register port: one access per request, answered next cycle
  always_comb begin
    cfg_dec = cfg_decode(reg_addr_i);
    cfg_hit = cfg_dec[6];
    cfg_idx = cfg_dec[5:0];
    cfg_ok = cfg_valid(int'(cfg_idx) % pli_pkg::BLK_REGS, reg_wdata_i);
    reg_hit = cfg_hit || reg_addr_i == pli_pkg::ADDR_MODE
      || reg_addr_i == pli_pkg::ADDR_JOB || reg_addr_i == pli_pkg::ADDR_ANIM
      || reg_addr_i == pli_pkg::ADDR_COLOR;
    next_mode = mode;
    next_job = job;
    next_b_anim = b_anim;
    next_b_color = b_color;
    next_ovr_anim = ovr_anim;
    next_ovr_color = ovr_color;
    if (reg_wr_i) begin
      if (reg_addr_i == pli_pkg::ADDR_MODE
          && reg_wdata_i <= pli_pkg::MODE_MAX)
        next_mode = reg_wdata_i;
      if (reg_addr_i == pli_pkg::ADDR_JOB && reg_wdata_i <= pli_pkg::JOB_MAX)
        next_job = reg_wdata_i;
      if (reg_addr_i == pli_pkg::ADDR_ANIM && anim_valid(reg_wdata_i)) begin
        next_b_anim = reg_wdata_i;
        next_ovr_anim = mode[0];
      end
      if (reg_addr_i == pli_pkg::ADDR_COLOR
          && reg_wdata_i <= pli_pkg::COLOR_MAX) begin
        next_b_color = reg_wdata_i;
        next_ovr_color = mode[0];
      end
      // a direct write to the job block takes back its own field
      if (cfg_hit && cfg_ok && cfg_idx == 6'(pli_pkg::BLK_JOB
          * pli_pkg::BLK_REGS + pli_pkg::F_ANIM))
        next_ovr_anim = 1'b0;
      if (cfg_hit && cfg_ok && cfg_idx == 6'(pli_pkg::BLK_JOB
          * pli_pkg::BLK_REGS + pli_pkg::F_COLOR1))
        next_ovr_color = 1'b0;
    end
    next_rdata = 16'h0000;
    if (cfg_hit)
      next_rdata = cfg[cfg_idx];
    else if (reg_addr_i == pli_pkg::ADDR_MODE)
      next_rdata = mode;
    else if (reg_addr_i == pli_pkg::ADDR_JOB)
      next_rdata = job;
    else if (reg_addr_i == pli_pkg::ADDR_ANIM)
      next_rdata = b_anim;
    else if (reg_addr_i == pli_pkg::ADDR_COLOR)
      next_rdata = b_color;
    next_tick_cnt = (tick_cnt >= 32'(TICK_CYCLES - 1)) ? 32'h0
      : tick_cnt + 32'h1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= pli_pkg::RST_REG;
      job <= pli_pkg::RST_REG;
      b_anim <= pli_pkg::RST_REG;
      b_color <= pli_pkg::RST_REG;
      ovr_anim <= 1'b0;
      ovr_color <= 1'b0;
      rdata <= 16'h0000;
      ack <= 1'b0;
      err <= 1'b0;
      tick_cnt <= 32'h0;
      tick <= 1'b0;
      for (int i = 0; i < pli_pkg::NUM_CFG; i++)
        cfg[i] <= pli_pkg::RST_REG;
    end else begin
      mode <= next_mode;
      job <= next_job;
      b_anim <= next_b_anim;
      b_color <= next_b_color;
      ovr_anim <= next_ovr_anim;
      ovr_color <= next_ovr_color;
      rdata <= (reg_rd_i && reg_hit) ? next_rdata : 16'h0000;
      ack <= reg_rd_i || reg_wr_i;
      err <= (reg_rd_i || reg_wr_i) && !reg_hit;
      tick_cnt <= next_tick_cnt;
      tick <= tick_cnt >= 32'(TICK_CYCLES - 1);
      if (reg_wr_i && cfg_hit && cfg_ok)
        cfg[cfg_idx] <= reg_wdata_i;
    end
  end

  // visual state machine; input on-delay and off-delay timers are kept here
  always_comb begin
    logic [15:0] on_dly;
    logic [15:0] cur;
    pli_state_t tgt;
    on_dly = cfg[state_blk(state) * pli_pkg::BLK_REGS + pli_pkg::F_ON_DLY];
    cur = 16'h0000;
    tgt = PLI_WAIT;
    next_state = state;
    next_pend = pend;
    next_pend_sec = pend_sec;
    next_dly = dly;
    if (!mode[0]) begin
      next_state = job[0] ? PLI_JOB : PLI_WAIT;
      next_pend = 1'b0;
      next_pend_sec = 1'b0;
      next_dly = 16'h0000;
    end else begin
      case (state)
        PLI_WAIT, PLI_JOB: begin
          if (pend || act_i || sec_act_i) begin
            cur = pend ? dly : on_dly;
            if (pend ? pend_sec : (sec_act_i && !act_i))
              tgt = PLI_SACK;
            else if (state == PLI_JOB)
              tgt = PLI_ACK;
            else
              tgt = PLI_MISPICK;
            if (cur == 16'h0000) begin
              next_state = tgt;
              next_pend = 1'b0;
              next_dly = cfg[state_blk(tgt) * pli_pkg::BLK_REGS
                + pli_pkg::F_OFF_DLY];
            end else begin
              next_pend = 1'b1;
              next_pend_sec = pend ? pend_sec : (sec_act_i && !act_i);
              next_dly = (tick && pend) ? dly - 16'h0001 : cur;
            end
          end else begin
            next_state = job[0] ? PLI_JOB : PLI_WAIT;
          end
        end
        PLI_MISPICK, PLI_ACK, PLI_SACK: begin
          if (dly != 16'h0000) begin
            if (tick)
              next_dly = dly - 16'h0001;
          end else if (!act_i && !sec_act_i) begin
            next_state = job[0] ? PLI_JOB : PLI_WAIT;
          end
        end
        default: next_state = PLI_WAIT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PLI_WAIT;
      pend <= 1'b0;
      pend_sec <= 1'b0;
      dly <= 16'h0000;
    end else begin
      state <= next_state;
      pend <= next_pend;
      pend_sec <= next_pend_sec;
      dly <= next_dly;
    end
  end

  // engine settings: basic registers, or the block of the current state
  always_comb begin
    logic [15:0] an;
    an = b_anim;
    blk = state_blk(state) * pli_pkg::BLK_REGS;
    anim_bus.tick = tick;
    anim_bus.burst = 4'h0;
    anim_bus.color2 = cfg[blk + pli_pkg::F_COLOR2][3:0];
    anim_bus.speed = cfg[blk + pli_pkg::F_SPEED][7:0];
    anim_bus.dir = cfg[blk + pli_pkg::F_DIR][0];
    anim_bus.pattern = cfg[blk + pli_pkg::F_PATTERN][2:0];
    anim_bus.anim = cfg[blk + pli_pkg::F_ANIM][3:0];
    anim_bus.color1 = cfg[blk + pli_pkg::F_COLOR1][3:0];
    if (mode[0] && state == PLI_JOB && ovr_color)
      anim_bus.color1 = b_color[3:0];
    if (!mode[0])
      anim_bus.color1 = b_color[3:0];
    if (!mode[0] || (state == PLI_JOB && ovr_anim)) begin
      anim_bus.speed = 8'h00;
      anim_bus.dir = 1'b0;
      anim_bus.pattern = pli_pkg::PT_NORMAL;
      case (an)
        16'h0000: anim_bus.anim = pli_pkg::AN_OFF;
        16'h0001: anim_bus.anim = pli_pkg::AN_STEADY;
        16'h0002: anim_bus.anim = pli_pkg::AN_FLASH;
        16'h0003: begin
          anim_bus.anim = pli_pkg::AN_FLASH;
          anim_bus.pattern = pli_pkg::PT_STROBE;
        end
        default: begin
          anim_bus.anim = pli_pkg::AN_FLASH;
          anim_bus.pattern = pli_pkg::PT_BURST;
          anim_bus.burst = 4'(an - pli_pkg::BURST_OFS);
        end
      endcase
    end
  end

  pli_anim u_anim (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .a(anim_bus.eng)
  );

  assign reg_rdata_o = rdata;
  assign reg_ack_o = ack;
  assign reg_err_o = err;
  assign vis_state_o = state;
  assign quad_color_o = anim_bus.quad;
  assign level_o = anim_bus.level;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_basic_follows_job;
    !mode[0] && !reg_wr_i |=> state == (job[0] ? PLI_JOB : PLI_WAIT);
  endproperty
  a_basic_follows_job: assert property (p_basic_follows_job)
    else $error("basic mode state does not follow job input");
  property p_mispick;
    mode[0] && state == PLI_WAIT && !pend && act_i
      && cfg[pli_pkg::BLK_WAIT * pli_pkg::BLK_REGS + pli_pkg::F_ON_DLY] == 0
      |=> state == PLI_MISPICK;
  endproperty
  a_mispick: assert property (p_mispick)
    else $error("actuation while waiting did not give mispick");
  property p_ack;
    mode[0] && state == PLI_JOB && !pend && act_i
      && cfg[pli_pkg::BLK_JOB * pli_pkg::BLK_REGS + pli_pkg::F_ON_DLY] == 0
      |=> state == PLI_ACK;
  endproperty
  a_ack: assert property (p_ack)
    else $error("actuation in job did not give acknowledge at once");
  property p_on_hold;
    mode[0] && pend && dly > 16'h0001 && !reg_wr_i |=> $stable(state);
  endproperty
  a_on_hold: assert property (p_on_hold)
    else $error("visual state moved during on-delay");
  property p_off_hold;
    mode[0] && state == PLI_ACK && dly != 16'h0000 && !reg_wr_i
      |=> state == PLI_ACK;
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("acknowledge left before its off-delay ran out");
  property p_return;
    mode[0] && state == PLI_ACK && dly == 16'h0000 && !act_i && !sec_act_i
      && !reg_wr_i |=> state == (job[0] ? PLI_JOB : PLI_WAIT);
  endproperty
  a_return: assert property (p_return)
    else $error("no return to wait or job after off-delay");
  property p_color_reject;
    reg_wr_i && reg_addr_i == pli_pkg::ADDR_COLOR
      && reg_wdata_i > pli_pkg::COLOR_MAX |=> $stable(b_color);
  endproperty
  a_color_reject: assert property (p_color_reject)
    else $error("out of range colour was stored");
  property p_unmapped;
    reg_rd_i && !reg_hit |=> reg_err_o && reg_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not answered with zero and error");
  property p_override;
    mode[0] && reg_wr_i && reg_addr_i == pli_pkg::ADDR_ANIM
      && anim_valid(reg_wdata_i) |=> ovr_anim;
  endproperty
  a_override: assert property (p_override)
    else $error("state mode animation write did not override job");
  c_mispick: cover property (mode[0] && state == PLI_MISPICK);
  c_ack_back: cover property (state == PLI_ACK ##1 state == PLI_JOB);
  c_sack: cover property (state == PLI_SACK);
  c_ovr_job: cover property (state == PLI_JOB && ovr_anim && ovr_color);
endmodule

/* File: src/pli_pkg.sv */
// shared constants for the pick-light indicator state controller
package pli_pkg;
  // register addresses
  localparam logic [15:0] ADDR_MODE = 16'h189c;
  localparam logic [15:0] ADDR_CFG_BASE = 16'h189d;
  localparam logic [15:0] ADDR_JOB = 16'h21fc;
  localparam logic [15:0] ADDR_ANIM = 16'h21fd;
  localparam logic [15:0] ADDR_COLOR = 16'h21fe;
  // five config blocks, ten registers each, eleven addresses apart
  localparam int NUM_BLK = 5;
  localparam int BLK_REGS = 10;
  localparam int BLK_STRIDE = 11;
  localparam int NUM_CFG = NUM_BLK * BLK_REGS;
  localparam int BLK_WAIT = 0;
  localparam int BLK_MISPICK = 1;
  localparam int BLK_JOB = 2;
  localparam int BLK_ACK = 3;
  localparam int BLK_SACK = 4;
  // field positions inside a block
  localparam int F_ANIM = 0;
  localparam int F_COLOR1 = 1;
  localparam int F_COLOR2 = 2;
  localparam int F_SPEED = 5;
  localparam int F_PATTERN = 6;
  localparam int F_DIR = 7;
  localparam int F_ON_DLY = 8;
  localparam int F_OFF_DLY = 9;
  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  // field limits
  localparam logic [15:0] COLOR_MAX = 16'h000e;
  localparam logic [15:0] BASIC_ANIM_MAX = 16'h0003;
  localparam logic [15:0] BASIC_BURST_LO = 16'h000b;
  localparam logic [15:0] BASIC_BURST_HI = 16'h0014;
  localparam logic [15:0] BURST_OFS = 16'h000a;
  localparam logic [15:0] MODE_MAX = 16'h0001;
  localparam logic [15:0] JOB_MAX = 16'h0001;
  // per-state animation codes
  localparam logic [3:0] AN_OFF = 4'h0;
  localparam logic [3:0] AN_STEADY = 4'h1;
  localparam logic [3:0] AN_FLASH = 4'h2;
  localparam logic [3:0] AN_TWO = 4'h3;
  localparam logic [3:0] AN_HALF_TB = 4'h4;
  localparam logic [3:0] AN_HALF_LR = 4'h5;
  localparam logic [3:0] AN_ROTATE = 4'h6;
  localparam logic [3:0] AN_CHASE = 4'h7;
  localparam logic [3:0] AN_SWEEP = 4'h8;
  // pattern codes; burst is internal, used by basic animations 11..20
  localparam logic [2:0] PT_NORMAL = 3'h0;
  localparam logic [2:0] PT_STROBE = 3'h1;
  localparam logic [2:0] PT_PULSE3 = 3'h2;
  localparam logic [2:0] PT_SOS = 3'h3;
  localparam logic [2:0] PT_RANDOM = 3'h4;
  localparam logic [2:0] PT_BURST = 3'h5;
  localparam logic [2:0] PT_MAX = 3'h4;
  // flash timing: ten phases per flash
  localparam logic [3:0] PH_LAST = 4'h9;
  localparam logic [3:0] PH_HALF = 4'h5;
  localparam logic [3:0] PH_FIFTH = 4'h2;
  localparam logic [3:0] PH_QUICK = 4'h3;
  localparam logic [3:0] PH_SLOW = 4'h8;
  localparam logic [3:0] SOS_LEN = 4'h9;
  localparam logic [3:0] SOS_SLOW_LO = 4'h3;
  localparam logic [3:0] SOS_SLOW_HI = 4'h5;
  localparam logic [3:0] PULSE3_LEN = 4'h3;
  localparam logic [7:0] LEVEL_STEP = 8'h10;
  localparam logic [7:0] LEVEL_FULL = 8'hff;
  localparam logic [7:0] STEP_MS_UNIT = 8'h0a;
  // timing: one millisecond tick
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
endpackage

/* File: src/pli_anim_if.sv */
// carrier between the state controller and the animation engine
`timescale 1ns/1ps
interface pli_anim_if;
  logic tick;
  logic [3:0] anim;
  logic [2:0] pattern;
  logic [3:0] burst;
  logic [3:0] color1;
  logic [3:0] color2;
  logic [7:0] speed;
  logic dir;
  logic [15:0] quad;
  logic [7:0] level;
  modport ctrl (output tick, anim, pattern, burst, color1, color2, speed,
    dir, input quad, level);
  modport eng (input tick, anim, pattern, burst, color1, color2, speed,
    dir, output quad, level);
endinterface

/* File: src/pli_anim.sv */
// animation engine: four quadrant colours and a brightness level
`timescale 1ns/1ps
module pli_anim (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  pli_anim_if.eng a
);
  logic [15:0] step_ms, next_step_ms;
  logic [3:0] phase, next_phase;
  logic [3:0] fl_idx, next_fl_idx;
  logic [1:0] pos, next_pos;
  logic [7:0] lvl, next_lvl;
  logic lvl_dn, next_lvl_dn;
  logic [7:0] lfsr, next_lfsr;
  logic rnd_on, next_rnd_on;
  logic [15:0] quad, next_quad;
  logic [7:0] level, next_level;
  logic [15:0] step_len;
  logic [3:0] lim;
  logic gate, step_end, flash_end;

  always_comb begin
    step_len = (16'(a.speed) + 16'h0001) * 16'(pli_pkg::STEP_MS_UNIT);
    step_end = a.tick && (step_ms + 16'h0001 >= step_len);
    flash_end = step_end && (phase == pli_pkg::PH_LAST);
    case (a.pattern)
      pli_pkg::PT_PULSE3: lim = pli_pkg::PULSE3_LEN;
      pli_pkg::PT_BURST: lim = a.burst;
      pli_pkg::PT_SOS: lim = pli_pkg::SOS_LEN;
      default: lim = 4'h0;
    endcase
    case (a.pattern)
      pli_pkg::PT_STROBE: gate = phase < pli_pkg::PH_FIFTH;
      pli_pkg::PT_PULSE3, pli_pkg::PT_BURST:
        gate = (fl_idx < lim) && (phase < pli_pkg::PH_HALF);
      pli_pkg::PT_SOS: begin
        // slow flashes are the middle three: long on-time
        if (fl_idx >= pli_pkg::SOS_SLOW_LO && fl_idx <= pli_pkg::SOS_SLOW_HI)
          gate = (fl_idx < lim) && (phase < pli_pkg::PH_SLOW);
        else
          gate = (fl_idx < lim) && (phase < pli_pkg::PH_QUICK);
      end
      pli_pkg::PT_RANDOM: gate = rnd_on && (phase < pli_pkg::PH_HALF);
      default: gate = phase < pli_pkg::PH_HALF;
    endcase
    next_step_ms = step_ms;
    next_phase = phase;
    next_fl_idx = fl_idx;
    next_pos = pos;
    next_lvl = lvl;
    next_lvl_dn = lvl_dn;
    next_lfsr = lfsr;
    next_rnd_on = rnd_on;
    if (a.tick) begin
      next_step_ms = step_end ? 16'h0000 : step_ms + 16'h0001;
      next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
    if (step_end) begin
      next_phase = flash_end ? 4'h0 : phase + 4'h1;
      next_pos = a.dir ? pos - 2'h1 : pos + 2'h1;
      // intensity sweep: ramp up to full, then down to zero
      if (lvl_dn) begin
        next_lvl = (lvl < pli_pkg::LEVEL_STEP) ? 8'h00
          : lvl - pli_pkg::LEVEL_STEP;
        next_lvl_dn = lvl >= pli_pkg::LEVEL_STEP;
      end else begin
        next_lvl = (lvl > pli_pkg::LEVEL_FULL - pli_pkg::LEVEL_STEP)
          ? pli_pkg::LEVEL_FULL : lvl + pli_pkg::LEVEL_STEP;
        next_lvl_dn = lvl > pli_pkg::LEVEL_FULL - pli_pkg::LEVEL_STEP;
      end
    end
    if (flash_end) begin
      next_fl_idx = (fl_idx >= lim) ? 4'h0 : fl_idx + 4'h1;
      next_rnd_on = lfsr[0];
    end
    next_level = pli_pkg::LEVEL_FULL;
    for (int i = 0; i < 4; i++) begin
      case (a.anim)
        pli_pkg::AN_STEADY: next_quad[4*i+:4] = a.color1;
        pli_pkg::AN_FLASH:
          next_quad[4*i+:4] = gate ? a.color1 : 4'h0;
        pli_pkg::AN_TWO:
          next_quad[4*i+:4] = gate ? a.color1 : a.color2;
        pli_pkg::AN_HALF_TB:
          next_quad[4*i+:4] = (i < 2) ? a.color1 : a.color2;
        pli_pkg::AN_HALF_LR:
          next_quad[4*i+:4] = (i == 0 || i == 3) ? a.color1 : a.color2;
        pli_pkg::AN_ROTATE:
          next_quad[4*i+:4] = (2'(i) == pos || 2'(i) == pos + 2'h1)
            ? a.color1 : a.color2;
        pli_pkg::AN_CHASE:
          next_quad[4*i+:4] = (2'(i) == pos) ? a.color1 : a.color2;
        pli_pkg::AN_SWEEP: next_quad[4*i+:4] = a.color1;
        default: next_quad[4*i+:4] = 4'h0;
      endcase
    end
    if (a.anim == pli_pkg::AN_SWEEP)
      next_level = lvl;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_ms <= 16'h0000;
      phase <= 4'h0;
      fl_idx <= 4'h0;
      pos <= 2'h0;
      lvl <= 8'h00;
      lvl_dn <= 1'b0;
      lfsr <= 8'h5a;
      rnd_on <= 1'b0;
      quad <= 16'h0000;
      level <= 8'h00;
    end else begin
      step_ms <= next_step_ms;
      phase <= next_phase;
      fl_idx <= next_fl_idx;
      pos <= next_pos;
      lvl <= next_lvl;
      lvl_dn <= next_lvl_dn;
      lfsr <= next_lfsr;
      rnd_on <= next_rnd_on;
      quad <= next_quad;
      level <= next_level;
    end
  end

  assign a.quad = quad;
  assign a.level = level;
endmodule

/* File: tb/pli_master.sv */
// register master model: single-cycle read and write requests
`timescale 1ns/1ps
module pli_master (
  input wire logic sys_clk_i,
  output logic [15:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 16'h0000;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // released address and data lines show the inverse so stale values never look valid
  task automatic access(input logic wr, input logic [15:0] a,
    input logic [15:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

/* File: tb/pli_ctrl_tb_top.sv */
// self-checking bench for the indicator controller
`timescale 1ns/1ps
module pli_ctrl_tb_top;
  logic sys_clk_i, rst_i, act_i, sec_act_i, reg_wr_i, reg_rd_i;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, quad_color_o, v;
  logic reg_ack_o, reg_err_o;
  logic [4:0] vis_state_o;
  logic [7:0] level_o;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  int fail_count = 0, total_checks = 0, cyc = 0;
  pli_ctrl #(.TICK_CYCLES(8)) u_pli_ctrl (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .act_i(act_i),
    .sec_act_i(sec_act_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .reg_err_o(reg_err_o), .vis_state_o(vis_state_o),
    .quad_color_o(quad_color_o), .level_o(level_o));
  pli_master u_pli_master (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic fail(input string m);
    fail_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // note the expected answer, then issue the access
  task automatic acc(logic wr, logic [15:0] a, logic [15:0] d, logic er);
    exp_q.push_back({!wr, er, d});
    u_pli_master.access(wr, a, d);
  endtask
  task automatic w(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(logic [4:0] x);
    total_checks++;
    if (vis_state_o !== x) fail("visual state mismatch");
  endtask
  task automatic chkq(logic [15:0] q, logic [7:0] l);
    total_checks++;
    if (quad_color_o !== q || level_o !== l) fail("indicator mismatch");
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 6000) begin
      fail("timeout");
      report_and_stop();
    end
    if (reg_ack_o === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0) fail("unexpected ack");
      else begin
        e = exp_q.pop_front();
        if (reg_err_o !== e[16] || (e[17] && reg_rdata_o !== e[15:0]))
          fail("register answer mismatch");
      end
    end
  end
  initial begin
    {rst_i, act_i, sec_act_i} = 3'b100;
    v = 16'h0000;
    void'($urandom(32'h2e08fce1));
    w(20);
    rst_i = 1'b0;
    chk(5'h01);
    acc(0, pli_pkg::ADDR_MODE, 16'h0000, 0);
    acc(0, pli_pkg::ADDR_JOB, 16'h0000, 0);
    acc(0, 16'h18a7, 16'h0000, 1);
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom_range(14));
      acc(1, pli_pkg::ADDR_COLOR, v, 0);
      acc(0, pli_pkg::ADDR_COLOR, v, 0);
    end
    acc(1, pli_pkg::ADDR_COLOR, 16'h000f, 0);
    acc(0, pli_pkg::ADDR_COLOR, v, 0);
    v = 16'h0000;
    for (int i = 0; i <= 21; i++) begin
      if (i < 4 || (i > 10 && i < 21)) v = 16'(i);
      acc(1, pli_pkg::ADDR_ANIM, 16'(i), 0);
      acc(0, pli_pkg::ADDR_ANIM, v, 0);
    end
    v = 16'($urandom_range(14, 1));
    acc(1, pli_pkg::ADDR_ANIM, 16'h0001, 0);
    acc(1, pli_pkg::ADDR_COLOR, v, 0);
    w(3);
    chkq({4{v[3:0]}}, 8'hff);
    acc(1, pli_pkg::ADDR_JOB, 16'h0001, 0);
    act_i = 1'b1;
    w(4);
    chk(5'h02);
    act_i = 1'b0;
    acc(1, pli_pkg::ADDR_JOB, 16'h0000, 0);
    acc(1, pli_pkg::ADDR_MODE, 16'h0001, 0);
    w(3);
    chk(5'h01);
    act_i = 1'b1;
    w(3);
    chk(5'h04);
    act_i = 1'b0;
    w(3);
    chk(5'h01);
    acc(1, pli_pkg::ADDR_JOB, 16'h0001, 0);
    acc(1, 16'h18bb, 16'h0002, 0);
    acc(1, 16'h18c7, 16'h0003, 0);
    w(3);
    chk(5'h02);
    v = 16'($urandom_range(14, 1));
    acc(1, pli_pkg::ADDR_ANIM, 16'h0001, 0);
    acc(1, pli_pkg::ADDR_COLOR, v, 0);
    w(3);
    chkq({4{v[3:0]}}, 8'hff);
    act_i = 1'b1;
    w(3);
    chk(5'h02);
    w(24);
    chk(5'h08);
    act_i = 1'b0;
    w(3);
    chk(5'h08);
    chkq(16'h0000, 8'hff);
    w(40);
    chk(5'h02);
    sec_act_i = 1'b1;
    w(30);
    chk(5'h10);
    sec_act_i = 1'b0;
    w(40);
    chk(5'h02);
    w(3);
    report_and_stop();
  end
endmodule
